// ==== include/flash_cmd_cfg.svh ====
// Constants for the serial flash latch and erase command block
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_SUBSECTOR_ERASE 8'h20
`define OP_SECTOR_ERASE 8'hD8
`define OP_ARRAY_ERASE 8'hC7
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define FSR_PROT_BIT 1
`define FSR_ERASE_BIT 5
`define FSR_SUSP_BIT 6
`define FSR_READY_BIT 7
`define FSR_RESET 8'h80
// Erase times in microseconds, shortened by default for simulation
`define SUBSECTOR_ERASE_TIME_US 10
`define SECTOR_ERASE_TIME_US 20
`define ARRAY_ERASE_TIME_US 40
`define CLK_MHZ 40
`define US_TO_CYC(t) ((t) * `CLK_MHZ)
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_STATUS 8'h08
`define REG_IRQ_STAT 8'h0C
`define REG_IRQ_MASK 8'h10
`define SCK_HALF 4
`endif

// ==== include/flash_cmd_pkg.sv ====
// Types for the two ends of the flash command link: erase kinds for the device, engine states for the host
package flash_cmd_pkg;
   typedef enum logic [2:0] {
      ER_NONE = 3'b000,
      ER_SUBSECTOR = 3'b001,
      ER_SECTOR = 3'b010,
      ER_ARRAY = 3'b011
   } erase_kind_t;
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_SHIFT = 2'b01,
      H_GAP = 2'b10
   } host_state_t;
endpackage : flash_cmd_pkg

// ==== include/flash_link_if.sv ====
// Serial link between flash controller and flash device
interface flash_link_if;
   logic cs_n;
   logic sck;
   logic serial_line_zero;
   modport device (input cs_n, input sck, input serial_line_zero);
   modport host (output cs_n, output sck, output serial_line_zero);
endinterface : flash_link_if

// ==== verif/flash_cmd_sva.sv ====
// Checker on the serial link and the flash device status outputs
module flash_cmd_sva (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic erase_fail_i,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic serial_line_zero,
   input wire logic wel_o,
   input wire logic wip_o,
   input wire logic [7:0] flag_status_o,
   input wire logic erase_start_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cs_q;
   logic sck_q;
   logic [5:0] bits;
   logic [3:0] age;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge clk_i) begin
      cs_q <= cs_n;
      sck_q <= sck;
   end
   // Rising clock edges seen inside one frame
   always_ff @(posedge clk_i) begin
      if (!cs_n && cs_q) begin
         bits <= 6'h00;
      end else if (!cs_n && sck && !sck_q) begin
         bits <= bits + 6'h01;
      end
   end
   // Cycles since select went high, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         age <= 4'hF;
      end else if (cs_n && !cs_q) begin
         age <= 4'h0;
      end else if (age != 4'hF) begin
         age <= age + 4'h1;
      end
   end
   sequence s_start;
      erase_start_o;
   endsequence
   sequence s_busy;
      wip_o [*8];
   endsequence
   // A failed erase may end at once, so busy is only owed while no failure
   property p_busy;
      disable iff (rst_i || erase_fail_i) s_start |-> ##2 s_busy;
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy not held after erase start");
   property p_wel_drop;
      s_start |-> ##[1:3] !wel_o;
   endproperty
   a_wel_drop: assert property (p_wel_drop)
      else $error("latch not cleared by erase start");
   property p_start_rise;
      s_start |-> cs_n && age <= 4'h8;
   endproperty
   a_start_rise: assert property (p_start_rise)
      else $error("erase start not tied to select rise");
   property p_start_wel;
      s_start |-> $past(wel_o);
   endproperty
   a_start_wel: assert property (p_start_wel)
      else $error("erase started without latch");
   property p_wel_set;
      $rose(wel_o) |-> cs_n && age <= 4'h8;
   endproperty
   a_wel_set: assert property (p_wel_set)
      else $error("latch set outside select rise");
   property p_idle;
      cs_n |-> !sck;
   endproperty
   a_idle: assert property (p_idle)
      else $error("serial clock moves outside frame");
   property p_stable;
      $rose(sck) |-> $stable(serial_line_zero);
   endproperty
   a_stable: assert property (p_stable)
      else $error("data changes at rising clock");
   property p_frame;
      $rose(cs_n) |-> bits == 6'h08 || bits == 6'h20;
   endproperty
   a_frame: assert property (p_frame)
      else $error("frame not ended at byte boundary");
   property p_prot;
      $rose(flag_status_o[1]) |-> ##[0:1] (flag_status_o[5] && wel_o);
   endproperty
   a_prot: assert property (p_prot)
      else $error("protection refusal flags or latch wrong");
endmodule : flash_cmd_sva

// ==== verif/write_latch_erase_commands_tb.sv ====
// Bench joining host and device ends, plus a rule-breaking second link
`include "flash_cmd_cfg.svh"
module write_latch_erase_commands_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SSE = 150;
   localparam int SE = 400;
   localparam int BE = 250;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, fail = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rd, dat_o;
   logic ack, irq, wel, wip, est, wel_b, wip_b;
   logic [7:0] fsr, fsr_b;
   logic [23:0] eadr, cap_adr;
   logic [2:0] ekind, cap_kind;
   logic [127:0] lock = '0, prot = '0;
   int n_mismatch = 0, tests_run = 0, n_start = 0, wip_cyc = 0;
   flash_link_if link ();
   flash_link_if link_b ();
   always #12.5 clk_i = ~clk_i;
   flash_cmd_host u_flash_cmd_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wd), .dat_o(dat_o), .ack_o(ack),
      .irq_o(irq), .link(link.host));
   flash_cmd_device #(.TIMEOUT_CYC(500), .SSE_CYC(SSE), .SE_CYC(SE), .BE_CYC(BE))
      u_flash_cmd_device (.clk_i(clk_i), .rst_i(rst_i), .link(link.device),
      .sector_lock_i(lock), .sector_protect_i(prot), .erase_fail_i(fail), .wel_o(wel),
      .wip_o(wip), .flag_status_o(fsr), .erase_start_o(est), .erase_addr_o(eadr),
      .erase_kind_o(ekind));
   // Second device faces the bench driver that breaks framing on purpose
   flash_cmd_device u_flash_cmd_device_2 (.clk_i(clk_i), .rst_i(rst_i), .link(link_b.device),
      .sector_lock_i('0), .sector_protect_i('0), .erase_fail_i(1'b0), .wel_o(wel_b),
      .wip_o(wip_b), .flag_status_o(fsr_b), .erase_start_o(), .erase_addr_o(),
      .erase_kind_o());
   flash_cmd_sva u_flash_cmd_sva (.clk_i(clk_i), .rst_i(rst_i), .cs_n(link.cs_n),
      .sck(link.sck), .serial_line_zero(link.serial_line_zero), .wel_o(wel), .wip_o(wip),
      .flag_status_o(fsr), .erase_start_o(est), .erase_fail_i(fail));
   always @(posedge clk_i) begin
      if (est === 1'b1) begin
         n_start <= n_start + 1;
         cap_kind <= ekind;
         cap_adr <= eadr;
         wip_cyc <= 0;
      end else if (wip === 1'b1) begin
         wip_cyc <= wip_cyc + 1;
      end
   end
   task end_of_test;
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      // No cycle count assumed; only the watchdog ends a hung bus
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task cmd(input logic [7:0] op, input logic [23:0] a);
      int n;
      n = 0;
      wb(1'b1, `REG_ADDR, {8'h00, a});
      wb(1'b1, `REG_CTRL, {24'h00_0000, op});
      do begin
         wb(1'b0, `REG_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 200);
      if (n >= 200) n_mismatch++;
      // Margin for the device's select synchroniser
      repeat (20) @(posedge clk_i);
   endtask : cmd
   task wait_idle;
      int n;
      n = 0;
      while (wip !== 1'b0 && n < 3000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 3000) n_mismatch++;
      repeat (2) @(posedge clk_i);
   endtask : wait_idle
   task rst;
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask : rst
   task t_latch_irq;
      wb(1'b1, `REG_IRQ_MASK, 32'h1);
      cmd(`OP_LATCH_SET, 24'h0);
      chk("wel", 32'h1, wel);
      chk("irq", 32'h1, irq);
      wb(1'b0, `REG_IRQ_STAT, 32'h0);
      chk("irq_stat", 32'h1, rd);
      repeat (2) @(posedge clk_i);
      chk("irq", 32'h0, irq);
      wb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, rd);
      wb(1'b1, `REG_IRQ_MASK, 32'h0);
      cmd(`OP_LATCH_CLEAR, 24'h0);
      chk("wel", 32'h0, wel);
      chk("irq", 32'h0, irq);
      wb(1'b0, `REG_IRQ_STAT, 32'h0);
      chk("irq_stat", 32'h1, rd);
   endtask : t_latch_irq
   task t_erase(input logic [7:0] op, input int dur, input logic [2:0] k, input logic [23:0] ea);
      int s;
      s = n_start;
      cmd(`OP_LATCH_SET, 24'h0);
      cmd(op, 24'h12_3456);
      chk("start", s + 1, n_start);
      chk("kind", k, cap_kind);
      if (op != `OP_ARRAY_ERASE) chk("addr", ea, cap_adr);
      chk("wip", 32'h1, wip);
      chk("wel", 32'h0, wel);
      wait_idle();
      chk("time", 32'h1, wip_cyc >= dur - 3 && wip_cyc <= dur + 3);
      chk("fsr", 32'h80, fsr);
   endtask : t_erase
   task t_refuse;
      int s;
      s = n_start;
      cmd(`OP_SECTOR_ERASE, 24'h12_3456);
      chk("fsr", 32'h80, fsr);
      prot[18] <= 1'b1;
      cmd(`OP_LATCH_SET, 24'h0);
      cmd(`OP_SECTOR_ERASE, 24'h12_3456);
      chk("fsr", 32'hA2, fsr);
      chk("wel", 32'h1, wel);
      rst();
      prot[18] <= 1'b0;
      lock[5] <= 1'b1;
      cmd(`OP_LATCH_SET, 24'h0);
      cmd(`OP_ARRAY_ERASE, 24'h0);
      chk("fsr", 32'hA2, fsr);
      chk("wel", 32'h1, wel);
      chk("start", s, n_start);
      lock[5] <= 1'b0;
      rst();
   endtask : t_refuse
   task t_fail;
      fail <= 1'b1;
      cmd(`OP_LATCH_SET, 24'h0);
      cmd(`OP_SUBSECTOR_ERASE, 24'h00_1000);
      wait_idle();
      chk("wel", 32'h0, wel);
      chk("fsr", 32'hA0, fsr);
      fail <= 1'b0;
      rst();
   endtask : t_fail
   task t_suspend;
      cmd(`OP_LATCH_SET, 24'h0);
      cmd(`OP_SECTOR_ERASE, 24'h04_0000);
      cmd(`OP_SUSPEND, 24'h0);
      chk("susp", 32'h1, fsr[6]);
      // Longer than the whole erase: a running timer would finish it
      repeat (500) @(posedge clk_i);
      chk("susp", 32'h1, fsr[6]);
      cmd(`OP_RESUME, 24'h0);
      chk("susp", 32'h0, fsr[6]);
      wait_idle();
      chk("wip", 32'h0, wip);
   endtask : t_suspend
   task raw(input logic [31:0] b, input int n);
      link_b.cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         link_b.serial_line_zero <= b[i];
         repeat (4) @(posedge clk_i);
         link_b.sck <= 1'b1;
         repeat (4) @(posedge clk_i);
         link_b.sck <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      link_b.cs_n <= 1'b1;
      link_b.serial_line_zero <= ~b[0];
      repeat (12) @(posedge clk_i);
   endtask : raw
   task t_frame;
      raw({23'h0, `OP_LATCH_SET, 1'b0}, 9);
      chk("wel_b", 32'h0, wel_b);
      raw({24'h0, `OP_LATCH_SET}, 8);
      chk("wel_b", 32'h1, wel_b);
      raw({23'h0, `OP_LATCH_CLEAR, 1'b1}, 9);
      chk("wel_b", 32'h1, wel_b);
      raw({1'b0, `OP_SUBSECTOR_ERASE, 23'h0}, 31);
      chk("wip_b", 32'h0, wip_b);
      chk("fsr_b", 32'h80, fsr_b);
      chk("wel_b", 32'h1, wel_b);
   endtask : t_frame
   initial begin
      link_b.cs_n = 1'b1;
      link_b.sck = 1'b0;
      link_b.serial_line_zero = 1'b0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_latch_irq();
      t_erase(`OP_SUBSECTOR_ERASE, SSE, 3'h1, 24'h12_3000);
      t_erase(`OP_SECTOR_ERASE, SE, 3'h2, 24'h12_0000);
      t_erase(`OP_ARRAY_ERASE, BE, 3'h3, 24'h00_0000);
      t_refuse();
      t_fail();
      t_suspend();
      t_frame();
      end_of_test();
   end
   initial begin
      repeat (60000) @(posedge clk_i);
      n_mismatch++;
      end_of_test();
   end
endmodule : write_latch_erase_commands_tb

// ==== verilog/flash_cmd_device.sv ====
// Flash device end: write enable latch and erase command sequencing
//
// The Wishbone register port and the register addresses are this design's own decisions.
`include "flash_cmd_cfg.svh"
module flash_cmd_device #(
   parameter int SECTORS = 128,
   parameter int SUBSECTOR_BITS = 12,
   parameter int SECTOR_BITS = 16,
   parameter int TIMEOUT_CYC = 1 << 20,
   parameter int SSE_CYC = `US_TO_CYC(`SUBSECTOR_ERASE_TIME_US),
   parameter int SE_CYC = `US_TO_CYC(`SECTOR_ERASE_TIME_US),
   parameter int BE_CYC = `US_TO_CYC(`ARRAY_ERASE_TIME_US)
) (
   input wire logic clk_i,
   input wire logic rst_i,
   flash_link_if.device link,
   input wire logic [SECTORS-1:0] sector_lock_i,
   input wire logic [SECTORS-1:0] sector_protect_i,
   input wire logic erase_fail_i,
   output logic wel_o,
   output logic wip_o,
   output logic [7:0] flag_status_o,
   output logic erase_start_o,
   output logic [23:0] erase_addr_o,
   output logic [2:0] erase_kind_o
);
   // Erase times must stay under the timeout, or erases of that kind would fail
   if (SECTORS < 1 || SECTORS > (1 << (24 - SECTOR_BITS)) || SUBSECTOR_BITS > SECTOR_BITS ||
       SSE_CYC < 1 || SE_CYC < 1 || BE_CYC < 1 || SSE_CYC >= TIMEOUT_CYC ||
       SE_CYC >= TIMEOUT_CYC || BE_CYC >= TIMEOUT_CYC) begin : g_bad_param
      $error("flash_cmd_device parameters out of range");
   end
   logic [2:0] cs_sync_reg, sck_sync_reg, d_sync_reg;
   logic cs_n_reg, sck_reg, d_reg, sck_prev_reg;
   logic [7:0] op_reg;
   logic [23:0] addr_reg;
   logic [5:0] bit_cnt_reg;
   logic wel_reg, wip_reg, susp_reg, erase_start_reg;
   logic [7:0] fsr_reg;
   logic [31:0] timer_reg;
   logic [31:0] run_cyc_reg;
   flash_cmd_pkg::erase_kind_t kind_reg;
   logic sck_rise, cs_rise, cmd_done;

   // Three-stage capture; a change counts once stages two and three agree
   always_ff @(posedge clk_i) begin
      cs_sync_reg <= {cs_sync_reg[1:0], link.cs_n};
      sck_sync_reg <= {sck_sync_reg[1:0], link.sck};
      d_sync_reg <= {d_sync_reg[1:0], link.serial_line_zero};
      if (rst_i) begin
         cs_n_reg <= 1'b1;
         sck_reg <= 1'b0;
         d_reg <= 1'b0;
         sck_prev_reg <= 1'b0;
      end else begin
         if (cs_sync_reg[1] == cs_sync_reg[2]) cs_n_reg <= cs_sync_reg[2];
         if (sck_sync_reg[1] == sck_sync_reg[2]) sck_reg <= sck_sync_reg[2];
         if (d_sync_reg[1] == d_sync_reg[2]) d_reg <= d_sync_reg[2];
         sck_prev_reg <= sck_reg;
      end
   end

   // Data passes through the same pipeline as the clock, so it is stable at the edge
   assign sck_rise = sck_reg && !sck_prev_reg && !cs_n_reg;
   assign cs_rise = (cs_sync_reg[1] == cs_sync_reg[2]) && cs_sync_reg[2] && !cs_n_reg;

   function automatic logic needs_addr(input logic [7:0] op);
      needs_addr = (op == `OP_SUBSECTOR_ERASE) || (op == `OP_SECTOR_ERASE);
   endfunction : needs_addr

   // Shifter: opcode then address, most significant bit first
   always_ff @(posedge clk_i) begin
      if (rst_i || cs_n_reg) begin
         op_reg <= 8'h00;
         addr_reg <= 24'h00_0000;
         bit_cnt_reg <= 6'h00;
      end else if (sck_rise) begin
         if (bit_cnt_reg < 6'h08) op_reg <= {op_reg[6:0], d_reg};
         else addr_reg <= {addr_reg[22:0], d_reg};
         if (bit_cnt_reg != 6'h3F) bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
   end

   // Select must rise exactly at the last byte boundary of the command
   assign cmd_done = cs_rise && (needs_addr(op_reg) ? bit_cnt_reg == 6'h20
                                                    : bit_cnt_reg == 6'h08);

   function automatic logic [31:0] sector_of(input logic [23:0] a);
      sector_of = 32'(a >> SECTOR_BITS);
   endfunction : sector_of

   // Latch, busy, flags and erase timer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wel_reg <= 1'b0;
         wip_reg <= 1'b0;
         susp_reg <= 1'b0;
         fsr_reg <= `FSR_RESET;
         timer_reg <= 32'h0000_0000;
         run_cyc_reg <= 32'h0000_0000;
         kind_reg <= flash_cmd_pkg::ER_NONE;
         erase_start_reg <= 1'b0;
         erase_addr_o <= 24'h00_0000;
      end else begin
         erase_start_reg <= 1'b0;
         if (wip_reg && !susp_reg) begin
            timer_reg <= timer_reg + 32'h0000_0001;
            if (erase_fail_i || timer_reg >= 32'(TIMEOUT_CYC)) begin
               wip_reg <= 1'b0;
               wel_reg <= 1'b0;
               fsr_reg[`FSR_ERASE_BIT] <= 1'b1;
               fsr_reg[`FSR_READY_BIT] <= 1'b1;
               kind_reg <= flash_cmd_pkg::ER_NONE;
            end else if (timer_reg + 32'h0000_0001 >= run_cyc_reg) begin
               wip_reg <= 1'b0;
               fsr_reg[`FSR_READY_BIT] <= 1'b1;
               kind_reg <= flash_cmd_pkg::ER_NONE;
            end
         end
         if (cmd_done) begin
            case (op_reg)
               `OP_LATCH_SET: if (!wip_reg) wel_reg <= 1'b1;
               `OP_LATCH_CLEAR: wel_reg <= 1'b0;
               `OP_SUSPEND: begin
                  if (wip_reg && !susp_reg && kind_reg != flash_cmd_pkg::ER_ARRAY) begin
                     susp_reg <= 1'b1;
                     fsr_reg[`FSR_SUSP_BIT] <= 1'b1;
                  end
               end
               `OP_RESUME: begin
                  if (susp_reg) begin
                     susp_reg <= 1'b0;
                     fsr_reg[`FSR_SUSP_BIT] <= 1'b0;
                  end
               end
               `OP_SUBSECTOR_ERASE, `OP_SECTOR_ERASE, `OP_ARRAY_ERASE: begin
                  if (wel_reg && !wip_reg) begin
                     if ((op_reg == `OP_ARRAY_ERASE && |sector_lock_i) ||
                         (op_reg != `OP_ARRAY_ERASE &&
                          sector_protect_i[sector_of(addr_reg)])) begin
                        fsr_reg[`FSR_PROT_BIT] <= 1'b1;
                        fsr_reg[`FSR_ERASE_BIT] <= 1'b1;
                     end else begin
                        wip_reg <= 1'b1;
                        wel_reg <= 1'b0;
                        fsr_reg[`FSR_READY_BIT] <= 1'b0;
                        timer_reg <= 32'h0000_0000;
                        erase_start_reg <= 1'b1;
                        case (op_reg)
                           `OP_SUBSECTOR_ERASE: begin
                              kind_reg <= flash_cmd_pkg::ER_SUBSECTOR;
                              run_cyc_reg <= 32'(SSE_CYC);
                              erase_addr_o <= (addr_reg >> SUBSECTOR_BITS) << SUBSECTOR_BITS;
                           end
                           `OP_SECTOR_ERASE: begin
                              kind_reg <= flash_cmd_pkg::ER_SECTOR;
                              run_cyc_reg <= 32'(SE_CYC);
                              erase_addr_o <= (addr_reg >> SECTOR_BITS) << SECTOR_BITS;
                           end
                           default: begin
                              kind_reg <= flash_cmd_pkg::ER_ARRAY;
                              run_cyc_reg <= 32'(BE_CYC);
                              erase_addr_o <= 24'h00_0000;
                           end
                        endcase
                     end
                  end
               end
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wel_o <= 1'b0;
         wip_o <= 1'b0;
         flag_status_o <= `FSR_RESET;
         erase_kind_o <= 3'b000;
         erase_start_o <= 1'b0;
      end else begin
         wel_o <= wel_reg;
         wip_o <= wip_reg;
         flag_status_o <= fsr_reg;
         erase_kind_o <= kind_reg;
         erase_start_o <= erase_start_reg;
      end
   end
endmodule : flash_cmd_device

// ==== verilog/flash_cmd_host.sv ====
// Flash controller end: Wishbone registers driving the serial link
`include "flash_cmd_cfg.svh"
module flash_cmd_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o,
   flash_link_if.host link
);
   flash_cmd_pkg::host_state_t state_reg;
   logic [31:0] shift_reg;
   logic [5:0] bits_left_reg;
   logic [7:0] div_reg;
   logic [7:0] op_reg;
   logic [23:0] addr_reg;
   logic busy_reg, done_reg;
   logic [7:0] irq_stat_reg, irq_mask_reg;
   logic go;

   assign go = cyc_i && stb_i && we_i && !ack_o && adr_i == `REG_CTRL && sel_i[0] && !busy_reg;

   // Wishbone slave: one wait state, ack for one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
         op_reg <= 8'h00;
         addr_reg <= 24'h00_0000;
         irq_mask_reg <= 8'h00;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
         dat_o <= 32'h0000_0000;
         if (cyc_i && stb_i && !ack_o) begin
            if (we_i) begin
               if (adr_i == `REG_CTRL && sel_i[0] && !busy_reg) op_reg <= dat_i[7:0];
               if (adr_i == `REG_ADDR && sel_i[0]) addr_reg[7:0] <= dat_i[7:0];
               if (adr_i == `REG_ADDR && sel_i[1]) addr_reg[15:8] <= dat_i[15:8];
               if (adr_i == `REG_ADDR && sel_i[2]) addr_reg[23:16] <= dat_i[23:16];
               if (adr_i == `REG_IRQ_MASK && sel_i[0]) irq_mask_reg <= dat_i[7:0];
            end else begin
               case (adr_i)
                  `REG_CTRL: dat_o <= {24'h00_0000, op_reg};
                  `REG_ADDR: dat_o <= {8'h00, addr_reg};
                  `REG_STATUS: dat_o <= {31'h0000_0000, busy_reg};
                  `REG_IRQ_STAT: dat_o <= {24'h00_0000, irq_stat_reg};
                  `REG_IRQ_MASK: dat_o <= {24'h00_0000, irq_mask_reg};
                  default: dat_o <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   // Done event sticky; set wins over the clearing read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_reg <= 8'h00;
         irq_o <= 1'b0;
      end else begin
         if (cyc_i && stb_i && !ack_o && !we_i && adr_i == `REG_IRQ_STAT)
            irq_stat_reg <= {7'h00, done_reg};
         else if (done_reg)
            irq_stat_reg[0] <= 1'b1;
         irq_o <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // Serial engine: select low, full bytes MSB first, then raise select
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= flash_cmd_pkg::H_IDLE;
         link.cs_n <= 1'b1;
         link.sck <= 1'b0;
         link.serial_line_zero <= 1'b0;
         shift_reg <= 32'h0000_0000;
         bits_left_reg <= 6'h00;
         div_reg <= 8'h00;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         case (state_reg)
            flash_cmd_pkg::H_IDLE: begin
               if (go) begin
                  busy_reg <= 1'b1;
                  link.cs_n <= 1'b0;
                  shift_reg <= {dat_i[7:0], addr_reg};
                  link.serial_line_zero <= dat_i[7];
                  bits_left_reg <= (dat_i[7:0] == `OP_SUBSECTOR_ERASE ||
                                    dat_i[7:0] == `OP_SECTOR_ERASE) ? 6'h20 : 6'h08;
                  div_reg <= 8'h00;
                  state_reg <= flash_cmd_pkg::H_SHIFT;
               end
            end
            flash_cmd_pkg::H_SHIFT: begin
               div_reg <= div_reg + 8'h01;
               if (div_reg == 8'(`SCK_HALF - 1)) begin
                  div_reg <= 8'h00;
                  if (!link.sck) begin
                     link.sck <= 1'b1;
                     shift_reg <= {shift_reg[30:0], 1'b0};
                     bits_left_reg <= bits_left_reg - 6'h01;
                  end else begin
                     link.sck <= 1'b0;
                     link.serial_line_zero <= shift_reg[31];
                     if (bits_left_reg == 6'h00) begin
                        link.cs_n <= 1'b1;
                        state_reg <= flash_cmd_pkg::H_GAP;
                     end
                  end
               end
            end
            flash_cmd_pkg::H_GAP: begin
               div_reg <= div_reg + 8'h01;
               if (div_reg == 8'(`SCK_HALF * 2)) begin
                  busy_reg <= 1'b0;
                  done_reg <= 1'b1;
                  state_reg <= flash_cmd_pkg::H_IDLE;
               end
            end
            default: state_reg <= flash_cmd_pkg::H_IDLE;
         endcase
      end
   end
endmodule : flash_cmd_host
